// ==== include/byte_alu_cfg.svh ====
// constants for the byte alu: register offsets, field positions, reset values
`ifndef BYTE_ALU_CFG_SVH
`define BYTE_ALU_CFG_SVH

// avalon byte offsets, one aligned word each
`define ACCUM_OFS 5'h00
`define STATUS_OFS 5'h04
`define DIR_A_OFS 5'h08
`define DIR_B_OFS 5'h0C
`define DIR_C_OFS 5'h10
`define WATCHDOG_OFS 5'h14

// status field positions
`define CARRY_BIT 0
`define DIGIT_CARRY_BIT 1
`define ZERO_BIT 2
`define POWERDOWN_N_BIT 3
`define TIMEOUT_N_BIT 4

// direction-load operand codes
`define DIR_A_SEL 7'h05
`define DIR_B_SEL 7'h06
`define DIR_C_SEL 7'h07

// reset values and the prescaler's last count
`define DIR_RESET 8'hFF
`define ACCUM_RESET 8'h00
`define PRESCALE_LAST 8'hFF

`endif

// ==== include/byte_alu_pkg.sv ====
// types shared by the byte alu and its testbench
package byte_alu_pkg;

  // one-hot instruction codes from the decoder
  typedef enum logic [7:0] {
    sub_from_literal_op = 8'h01,
    sub_from_file_op = 8'h02,
    sub_with_borrow_op = 8'h04,
    nibble_exchange_op = 8'h08,
    xor_literal_op = 8'h10,
    xor_file_op = 8'h20,
    direction_load_op = 8'h40,
    sleep_op = 8'h80
  } op_t;

  // core run or sleep
  typedef enum logic [1:0] {
    run_mode = 2'h1,
    sleep_mode = 2'h2
  } mode_t;

  // one decoded instruction
  typedef struct packed {
    op_t op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic dest;
  } instr_t;

  // write back into the file registers
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  // status flags, bit 0 is carry
  typedef struct packed {
    logic timeout_status_n;
    logic powerdown_status_n;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } status_t;

  // whole state of the alu
  typedef struct packed {
    mode_t mode;
    logic [7:0] accum;
    status_t status;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic [7:0] watchdog_counter;
    logic [7:0] prescaler;
    file_wr_t fwr;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage : byte_alu_pkg

// ==== hw/byte_subtractor.sv ====
// 8-bit subtractor with borrow in, carry and digit carry out
`timescale 1ns/1ps
`default_nettype none

module byte_subtractor (
  input wire logic [7:0] minuend_i,    // value subtracted from
  input wire logic [7:0] subtrahend_i, // value taken away
  input wire logic carry_in_i,         // 1 means no borrow
  output logic [7:0] diff_o,           // two's complement result
  output logic carry_o,                // 1 means no borrow out
  output logic digit_carry_o           // 1 means no low-nibble borrow
);

  logic [8:0] full_sum; // minuend plus inverted subtrahend
  logic [4:0] low_sum;  // low nibble only

  ////////////////////////////////////////////////////////////////////////
  // add the one's complement plus carry in
  always_comb
  begin
    full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {8'h00, carry_in_i};
    low_sum = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + {4'h0, carry_in_i};
    diff_o = full_sum[7:0];
    carry_o = full_sum[8];
    digit_carry_o = low_sum[4];
  end

endmodule : byte_subtractor

`default_nettype wire

// ==== hw/byte_alu.sv ====
// execution of a subset of the byte instructions with an avalon register port
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

`include "byte_alu_cfg.svh"

// Contract
// RL1: literal minus accumulator into accumulator, flags
// RL2: literal carry and digit carry as no-borrow
// RL3: sleep clears watchdog counter and prescaler
// RL4: sleep clears powerdown, sets timeout flag
// RL5: sleep enters low-power state, oscillator halted
// RL6: file minus accumulator, updating three flags
// RL7: file carry and digit carry as no-borrow
// RL8: destination bit picks accumulator or file
// RL9: borrow subtract uses inverted carry flag
// RL10: nibble swap, no flags touched
// RL11: xor literal into accumulator, zero only
// RL12: xor file, routed, zero only
// RL13: direction load copies accumulator, no flags
// RL14: zero flag set when result is zero
module byte_alu
  import byte_alu_pkg::*;
(
  input wire logic clk_i,                    // core clock, 25 MHz
  input wire logic rst_i,                    // synchronous reset, high
  input wire logic instr_valid_i,            // decoder offers an instruction
  input wire instr_t instr_i,                // decoded instruction
  output logic instr_ready_o,                // high while running
  input wire logic [7:0] file_data_i,        // addressed file register value
  input wire logic wake_i,                   // wake from sleep
  input wire logic [4:0] avs_address_i,      // byte address
  input wire logic avs_read_i,               // avalon read
  input wire logic avs_write_i,              // avalon write
  input wire logic [31:0] avs_writedata_i,   // avalon write data
  input wire logic [3:0] avs_byteenable_i,   // avalon byte lanes
  output logic [31:0] avs_readdata_o,        // avalon read data
  output logic avs_waitrequest_o,            // avalon stall
  output var file_wr_t file_wr_o,            // write back to file register
  output logic [7:0] accumulator_o,          // accumulator
  output var status_t status_o,              // status flags
  output logic [7:0] port_a_direction_o,     // port a direction
  output logic [7:0] port_b_direction_o,     // port b direction
  output logic [7:0] port_c_direction_o,     // port c direction
  output logic sleep_o                       // sleeping, oscillator halted
);

  state_t s_q; // registered state
  state_t s_d; // next state

  logic exec;                // instruction taken this cycle
  logic bus_req;             // avalon request pending
  logic bus_wr_now;          // write takes effect this edge
  logic [7:0] sub_minuend;   // subtractor left operand
  logic sub_carry_in;        // subtractor carry in
  logic [7:0] sub_diff;      // subtractor result
  logic sub_carry;           // subtractor carry out
  logic sub_digit_carry;     // subtractor digit carry out
  logic [31:0] read_mux;     // word for the addressed register
  logic [7:0] result;        // result of the current op
  logic result_valid;        // op produces a routed result

  ////////////////////////////////////////////////////////////////////////
  // zero test on an 8-bit result
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  ////////////////////////////////////////////////////////////////////////
  // handshake and operand selection
  assign exec = instr_valid_i && (s_q.mode == run_mode);
  assign instr_ready_o = (s_q.mode == run_mode);
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_wr_now = avs_write_i && s_q.ack;
  assign avs_waitrequest_o = bus_req && !s_q.ack;
  // RL1: literal is minuend
  assign sub_minuend = (instr_i.op == sub_from_literal_op) ? instr_i.literal : file_data_i;
  // RL9: borrow is inverted carry
  assign sub_carry_in = (instr_i.op == sub_with_borrow_op) ? s_q.status.carry : 1'b1;

  // shared subtractor, accumulator always subtrahend
  byte_subtractor u_sub (
    .minuend_i(sub_minuend),
    .subtrahend_i(s_q.accum),
    .carry_in_i(sub_carry_in),
    .diff_o(sub_diff),
    .carry_o(sub_carry),
    .digit_carry_o(sub_digit_carry)
  );

  ////////////////////////////////////////////////////////////////////////
  // register read selection
  always_comb
  begin
    read_mux = 32'h0000_0000;
    unique case (avs_address_i)
      `ACCUM_OFS: read_mux[7:0] = s_q.accum;
      `STATUS_OFS: read_mux[4:0] = s_q.status;
      `DIR_A_OFS: read_mux[7:0] = s_q.port_a_direction;
      `DIR_B_OFS: read_mux[7:0] = s_q.port_b_direction;
      `DIR_C_OFS: read_mux[7:0] = s_q.port_c_direction;
      `WATCHDOG_OFS: read_mux[15:0] = {s_q.watchdog_counter, s_q.prescaler};
      default: read_mux = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.fwr.we = 1'b0;
    s_d.ack = 1'b0;
    result = 8'h00;
    result_valid = 1'b0;
    // first bus cycle: capture read data, then release
    if (bus_req && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      s_d.rdata = read_mux;
    end
    // bus write lands at the edge without wait
    if (bus_wr_now && avs_byteenable_i[0])
    begin
      unique case (avs_address_i)
        `ACCUM_OFS: s_d.accum = avs_writedata_i[7:0];
        `STATUS_OFS: s_d.status = avs_writedata_i[4:0];
        `DIR_A_OFS: s_d.port_a_direction = avs_writedata_i[7:0];
        `DIR_B_OFS: s_d.port_b_direction = avs_writedata_i[7:0];
        `DIR_C_OFS: s_d.port_c_direction = avs_writedata_i[7:0];
        default: ; // read-only or unmapped, ignored
      endcase
    end
    // watchdog prescaler and counter run freely
    s_d.prescaler = s_q.prescaler + 8'h01;
    if (s_q.prescaler == `PRESCALE_LAST)
    begin
      s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
    end
    // instruction execution overrides a same-cycle bus write
    if (exec)
    begin
      unique case (instr_i.op)
        sub_from_literal_op:
        begin
          // RL1: literal minus accumulator
          s_d.accum = sub_diff;
          // RL2: no-borrow flags
          s_d.status.carry = sub_carry;
          s_d.status.digit_carry_flag = sub_digit_carry;
          // RL14: zero on result
          s_d.status.zero = is_zero(sub_diff);
        end
        sub_from_file_op, sub_with_borrow_op:
        begin
          // RL6: file minus accumulator
          result = sub_diff;
          result_valid = 1'b1;
          // RL7: no-borrow flags
          s_d.status.carry = sub_carry;
          s_d.status.digit_carry_flag = sub_digit_carry;
          // RL14: zero on result
          s_d.status.zero = is_zero(sub_diff);
        end
        nibble_exchange_op:
        begin
          // RL10: swap nibbles, flags kept
          result = {file_data_i[3:0], file_data_i[7:4]};
          result_valid = 1'b1;
        end
        xor_literal_op:
        begin
          // RL11: xor literal, zero only
          s_d.accum = s_q.accum ^ instr_i.literal;
          s_d.status.zero = is_zero(s_q.accum ^ instr_i.literal);
        end
        xor_file_op:
        begin
          // RL12: xor file, zero only
          result = s_q.accum ^ file_data_i;
          result_valid = 1'b1;
          s_d.status.zero = is_zero(s_q.accum ^ file_data_i);
        end
        direction_load_op:
        begin
          // RL13: copy accumulator to direction
          unique case (instr_i.file_addr)
            `DIR_A_SEL: s_d.port_a_direction = s_q.accum;
            `DIR_B_SEL: s_d.port_b_direction = s_q.accum;
            `DIR_C_SEL: s_d.port_c_direction = s_q.accum;
            default: ; // other operands do nothing
          endcase
        end
        sleep_op:
        begin
          // RL3: clear watchdog and prescaler
          s_d.watchdog_counter = 8'h00;
          s_d.prescaler = 8'h00;
          // RL4: powerdown low, timeout high
          s_d.status.powerdown_status_n = 1'b0;
          s_d.status.timeout_status_n = 1'b1;
          // RL5: enter sleep
          s_d.mode = sleep_mode;
        end
        default: ; // illegal code, no effect
      endcase
      // RL8: destination bit routes result
      if (result_valid)
      begin
        if (instr_i.dest)
        begin
          s_d.fwr.we = 1'b1;
          s_d.fwr.addr = instr_i.file_addr;
          s_d.fwr.data = result;
        end
        else
        begin
          s_d.accum = result;
        end
      end
    end
    // leave sleep on wake
    if ((s_q.mode == sleep_mode) && wake_i)
    begin
      s_d.mode = run_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= run_mode;
      s_q.accum <= `ACCUM_RESET;
      s_q.status.timeout_status_n <= 1'b1;
      s_q.status.powerdown_status_n <= 1'b1;
      s_q.port_a_direction <= `DIR_RESET;
      s_q.port_b_direction <= `DIR_RESET;
      s_q.port_c_direction <= `DIR_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from the state register
  assign avs_readdata_o = s_q.rdata;
  assign file_wr_o = s_q.fwr;
  assign accumulator_o = s_q.accum;
  assign status_o = s_q.status;
  assign port_a_direction_o = s_q.port_a_direction;
  assign port_b_direction_o = s_q.port_b_direction;
  assign port_c_direction_o = s_q.port_c_direction;
  assign sleep_o = (s_q.mode == sleep_mode);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // literal subtract result
  AST_LIT_SUB_RESULT: assert property (exec && instr_i.op == sub_from_literal_op // RL1
    |=> accumulator_o == 8'($past(instr_i.literal) - $past(s_q.accum)))
    else $error("literal subtract result wrong");

  // literal subtract carry and digit carry
  AST_LIT_SUB_FLAGS: assert property (exec && instr_i.op == sub_from_literal_op // RL2
    |=> status_o.carry == ($past(s_q.accum) <= $past(instr_i.literal))
     && status_o.digit_carry_flag == ($past(s_q.accum[3:0]) <= $past(instr_i.literal[3:0])))
    else $error("literal subtract flags wrong");

  // sleep clears the watchdog
  AST_SLEEP_WATCHDOG: assert property (exec && instr_i.op == sleep_op // RL3
    |=> s_q.watchdog_counter == 8'h00 && s_q.prescaler == 8'h00 ##1 s_q.prescaler == 8'h01)
    else $error("watchdog not cleared by sleep");

  // sleep flags, others kept
  AST_SLEEP_FLAGS: assert property (exec && instr_i.op == sleep_op && !bus_wr_now // RL4
    |=> !status_o.powerdown_status_n && status_o.timeout_status_n
     && $stable(status_o.carry) && $stable(status_o.zero) && $stable(status_o.digit_carry_flag))
    else $error("sleep status flags wrong");

  // sleep state entered, no instruction taken
  AST_SLEEP_ENTER: assert property (exec && instr_i.op == sleep_op // RL5
    |=> sleep_o && !instr_ready_o)
    else $error("sleep not entered");

  // file subtract carry and routing to accumulator
  AST_FILE_SUB_ACC: assert property (exec && instr_i.op == sub_from_file_op && !instr_i.dest // RL7
    |=> accumulator_o == 8'($past(file_data_i) - $past(s_q.accum))
     && status_o.carry == ($past(s_q.accum) <= $past(file_data_i)))
    else $error("file subtract wrong");

  // file destination writes file, leaves accumulator
  AST_DEST_FILE: assert property (exec && instr_i.dest && !bus_wr_now // RL8
    && (instr_i.op == xor_file_op || instr_i.op == sub_from_file_op)
    |=> file_wr_o.we && file_wr_o.addr == $past(instr_i.file_addr) && $stable(accumulator_o))
    else $error("file destination not honoured");

  // borrow subtract
  AST_BORROW_SUB: assert property (exec && instr_i.op == sub_with_borrow_op && !instr_i.dest // RL9
    |=> accumulator_o == 8'($past(file_data_i) - $past(s_q.accum) - {7'h00, !$past(s_q.status.carry)}))
    else $error("borrow subtract wrong");

  // nibble swap, flags untouched
  AST_SWAP: assert property (exec && instr_i.op == nibble_exchange_op && instr_i.dest && !bus_wr_now // RL10
    |=> file_wr_o.data == {$past(file_data_i[3:0]), $past(file_data_i[7:4])} && $stable(status_o))
    else $error("nibble swap wrong");

  // xor literal with zero flag
  AST_XOR_LIT: assert property (exec && instr_i.op == xor_literal_op // RL11
    |=> accumulator_o == ($past(s_q.accum) ^ $past(instr_i.literal))
     && status_o.zero == (accumulator_o == 8'h00))
    else $error("xor literal wrong");

  // direction load of port b
  AST_DIR_B: assert property (exec && instr_i.op == direction_load_op && instr_i.file_addr == `DIR_B_SEL // RL13
    |=> port_b_direction_o == $past(s_q.accum))
    else $error("direction load wrong");

  // file subtract written back to the file register
  AST_FILE_SUB_TO_FILE: assert property (exec && instr_i.op == sub_from_file_op && instr_i.dest // RL6
    |=> file_wr_o.we && file_wr_o.data == 8'($past(file_data_i) - $past(s_q.accum)))
    else $error("file subtract to file wrong");

  // xor with file touches only the zero flag
  AST_XOR_FILE: assert property (exec && instr_i.op == xor_file_op && !bus_wr_now // RL12
    |=> status_o.zero == (($past(s_q.accum) ^ $past(file_data_i)) == 8'h00)
     && $stable(status_o.carry) && $stable(status_o.digit_carry_flag))
    else $error("xor file flags wrong");

  // bus answers after one wait cycle
  AST_BUS_WAIT: assert property ($rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer timing wrong");

  COV_SLEEP_WAKE: cover property (exec && instr_i.op == sleep_op ##[1:20] !sleep_o);
  COV_BORROW: cover property (exec && instr_i.op == sub_with_borrow_op && !s_q.status.carry);
  COV_ZERO_XOR: cover property (exec && instr_i.op == xor_file_op ##1 status_o.zero);

endmodule : byte_alu

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the byte alu: instruction port and register bus
`timescale 1ns/1ps
`default_nettype none

`include "byte_alu_cfg.svh"

module tb
  import byte_alu_pkg::*;
;
  logic clk_i;                 // core clock
  logic rst_i;                 // synchronous reset
  logic instr_valid_i;         // instruction offered
  instr_t instr_i;             // decoded instruction
  logic [7:0] file_data_i;     // addressed file value
  logic wake_i;                // wake from sleep
  logic [4:0] avs_address_i;   // bus address
  logic avs_read_i;            // bus read
  logic avs_write_i;           // bus write
  logic [31:0] avs_writedata_i; // bus write data
  logic [3:0] avs_byteenable_i; // bus lanes
  wire logic instr_ready_o;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o;
  file_wr_t file_wr_o;
  wire logic [7:0] accumulator_o;
  status_t status_o;
  wire logic [7:0] port_a_direction_o;
  wire logic [7:0] port_b_direction_o;
  wire logic [7:0] port_c_direction_o;
  wire logic sleep_o;
  int fails;                   // mismatch count
  int compares;                // comparison count
  logic [7:0] acc;             // expected accumulator
  logic [4:0] st;              // expected status
  logic [23:0] dirs;           // expected directions a, b, c
  logic slp;                   // expected sleep level
  logic [31:0] v;              // scratch read value

  ////////////////////////////////////////////////////////////////////////////
  // design under test
  byte_alu DUT (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .file_data_i(file_data_i), .wake_i(wake_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .file_wr_o(file_wr_o), .accumulator_o(accumulator_o), .status_o(status_o),
    .port_a_direction_o(port_a_direction_o), .port_b_direction_o(port_b_direction_o),
    .port_c_direction_o(port_c_direction_o), .sleep_o(sleep_o));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // verdict and end of run
  task give_verdict;
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // one comparison
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // subtract with borrow: {no-borrow, nibble no-borrow, difference}
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic bw);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, bw};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
    return {~full[8], ~low[4], full[7:0]};
  endfunction : sub8

  // one bus transfer, held until waitrequest is sampled low
  task bus_xfer(input logic w, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be,
                output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100)
    begin
      fails++;
      $display("MISMATCH waitrequest expected 0 seen stuck");
    end
    rdv = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus_xfer

  // read and compare
  task rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus_xfer(1'b0, a, 32'h0, 4'hF, x);
    chk(nm, e, x);
  endtask : rd_chk

  // load the accumulator over the bus
  task set_acc(input logic [7:0] d);
    logic [31:0] x;
    bus_xfer(1'b1, `ACCUM_OFS, {24'h0, d}, 4'hF, x);
    acc = d;
  endtask : set_acc

  // issue one instruction, predict and compare its effect
  task run(input op_t op, input logic [7:0] lit, input logic [6:0] fa, input logic dest, input logic [7:0] fd);
    logic [9:0] r;
    logic cf;
    logic zf;
    logic route;
    logic d;
    logic wexp;
    r = 10'h0;
    cf = 1'b0;
    zf = 1'b0;
    route = 1'b0;
    d = 1'b0;
    wexp = 1'b0;
    case (op)
      sub_from_literal_op: begin r = sub8(lit, acc, 1'b0); cf = 1; zf = 1; route = 1; end
      sub_from_file_op: begin r = sub8(fd, acc, 1'b0); cf = 1; zf = 1; route = 1; d = dest; end
      sub_with_borrow_op: begin r = sub8(fd, acc, ~st[0]); cf = 1; zf = 1; route = 1; d = dest; end
      nibble_exchange_op: begin r = {2'b00, fd[3:0], fd[7:4]}; route = 1; d = dest; end
      xor_literal_op: begin r = {2'b00, acc ^ lit}; zf = 1; route = 1; end
      xor_file_op: begin r = {2'b00, acc ^ fd}; zf = 1; route = 1; d = dest; end
      direction_load_op:
      begin
        if (fa == `DIR_A_SEL) dirs[23:16] = acc;
        if (fa == `DIR_B_SEL) dirs[15:8] = acc;
        if (fa == `DIR_C_SEL) dirs[7:0] = acc;
      end
      sleep_op: begin st[4] = 1'b1; st[3] = 1'b0; slp = 1'b1; end
      default: ;
    endcase
    if (cf)
      st[1:0] = {r[8], r[9]};
    if (zf)
      st[2] = (r[7:0] == 8'h00);
    if (route && d)
      wexp = 1'b1;
    else if (route)
      acc = r[7:0];
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op: op, literal: lit, file_addr: fa, dest: dest};
    file_data_i <= fd;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    chk("accumulator", {24'h0, acc}, {24'h0, accumulator_o});
    chk("status", {27'h0, st}, {27'h0, status_o});
    chk("file_we", {31'h0, wexp}, {31'h0, file_wr_o.we});
    if (wexp)
      chk("file_word", {17'h0, fa, r[7:0]}, {17'h0, file_wr_o.addr, file_wr_o.data});
    chk("directions", {8'h0, dirs}, {8'h0, port_a_direction_o, port_b_direction_o, port_c_direction_o});
    chk("sleep", {31'h0, slp}, {31'h0, sleep_o});
    if (wexp)
    begin
      @(posedge clk_i);
      #1;
      chk("file_we_drop", 32'h0, {31'h0, file_wr_o.we});
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    fails = 0;
    compares = 0;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '{op: xor_literal_op, literal: 8'h00, file_addr: 7'h00, dest: 1'b0};
    file_data_i = 8'h00;
    wake_i = 1'b0;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    acc = `ACCUM_RESET;
    st = 5'h18;
    dirs = {3{`DIR_RESET}};
    slp = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and refused bus accesses
    rd_chk("accum_reset", `ACCUM_OFS, 32'h0);
    rd_chk("status_reset", `STATUS_OFS, 32'h18);
    rd_chk("dir_c_reset", `DIR_C_OFS, 32'hFF);
    bus_xfer(1'b1, 5'h18, 32'hAB, 4'hF, v);
    rd_chk("unmapped", 5'h18, 32'h0);
    set_acc(8'h3C);
    bus_xfer(1'b1, `ACCUM_OFS, 32'h55, 4'hE, v);
    rd_chk("lane_off", `ACCUM_OFS, 32'h3C);
    // status and direction registers written over the bus
    bus_xfer(1'b1, `STATUS_OFS, 32'h1A, 4'hF, v);
    rd_chk("status_write", `STATUS_OFS, 32'h1A);
    st = 5'h1A;
    bus_xfer(1'b1, `DIR_B_OFS, 32'h5A, 4'hF, v);
    rd_chk("dir_b_write", `DIR_B_OFS, 32'h5A);
    dirs[15:8] = 8'h5A;
    // literal minus accumulator over boundary pairs
    set_acc(8'h05); run(sub_from_literal_op, 8'h05, 7'h00, 1'b0, 8'h00);
    set_acc(8'h06); run(sub_from_literal_op, 8'h05, 7'h00, 1'b0, 8'h00);
    set_acc(8'h01); run(sub_from_literal_op, 8'h10, 7'h00, 1'b0, 8'h00);
    set_acc(8'hFF); run(sub_from_literal_op, 8'h00, 7'h00, 1'b0, 8'h00);
    // file minus accumulator, both destinations, both borrows
    set_acc(8'h30);
    run(sub_from_file_op, 8'h00, 7'h12, 1'b0, 8'h20);
    run(sub_with_borrow_op, 8'h00, 7'h7F, 1'b1, 8'h20);
    run(sub_from_file_op, 8'h00, 7'h00, 1'b1, 8'hF0);
    run(sub_with_borrow_op, 8'h00, 7'h01, 1'b0, 8'hF5);
    // nibble swap keeps flags
    run(nibble_exchange_op, 8'h00, 7'h21, 1'b0, 8'hA5);
    run(nibble_exchange_op, 8'h00, 7'h22, 1'b1, 8'h3C);
    // exclusive or, zero flag only
    run(xor_literal_op, acc, 7'h00, 1'b0, 8'h00);
    run(xor_literal_op, 8'h81, 7'h00, 1'b0, 8'h00);
    run(xor_file_op, 8'h00, 7'h40, 1'b1, 8'h81);
    run(xor_file_op, 8'h00, 7'h41, 1'b0, 8'h18);
    // direction loads, one bad operand, one bad code
    for (int i = 4; i < 8; i++)
    begin
      set_acc(8'h10 + i[7:0]);
      run(direction_load_op, 8'h00, i[6:0], 1'b0, 8'h00);
    end
    run(op_t'(8'h03), 8'h77, 7'h05, 1'b1, 8'h77);
    rd_chk("dir_a", `DIR_A_OFS, 32'h15);
    // sleep: flags, watchdog, halted core, wake
    run(sleep_op, 8'h00, 7'h00, 1'b0, 8'h00);
    chk("ready_sleep", 32'h0, {31'h0, instr_ready_o});
    bus_xfer(1'b0, `WATCHDOG_OFS, 32'h0, 4'hF, v);
    chk("watchdog_counter", 32'h0, {24'h0, v[15:8]});
    chk("prescaler", 32'h1, {24'h0, v[7:0]});
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op: xor_literal_op, literal: 8'hFF, file_addr: 7'h00, dest: 1'b0};
    repeat (2) @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    chk("accum_sleep", {24'h0, acc}, {24'h0, accumulator_o});
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    slp = 1'b0;
    #1;
    chk("woken", 32'h1, {31'h0, instr_ready_o & ~sleep_o});
    run(xor_literal_op, 8'h0F, 7'h00, 1'b0, 8'h00);
    give_verdict();
  end

endmodule : tb

`default_nettype wire
